// >>> swr_assertions.sv
// swr_assertions: port checks for swr_top
// assumes a bind onto swr_top, single clock pclk
`timescale 1ns/1ps
module swr_assertions (
  // clock and reset
  input wire logic        pclk, presetn,
  // apb
  input wire logic        psel, penable, pready,
  // window and memory
  input wire logic        win_rd, win_wr, mem_rd, mem_wr, mem_rvalid,
  input wire logic [3:0]  win_be, mem_be,
  input wire logic [31:0] win_wdata, mem_wdata, mem_rdata, win_rdata
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_acc; psel && penable && pready; endsequence
  property p_apb; s_setup |=> s_acc; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_rd; mem_rd |-> $past(win_rd); endproperty
  property p_wr; mem_wr |-> $past(win_wr); endproperty
  property p_wdat; mem_wr |-> mem_wdata == $past(win_wdata) && mem_be == $past(win_be);
  endproperty
  property p_be; !mem_wr |-> mem_be == 4'h0; endproperty
  property p_excl; !(mem_rd && mem_wr); endproperty
  property p_rdat; mem_rvalid |=> win_rdata == $past(mem_rdata); endproperty
  a_apb: assert property (p_apb) else $error("no answer after setup");
  a_pulse: assert property (p_pulse) else $error("pready too long");
  a_rd: assert property (p_rd) else $error("read without request");
  a_wr: assert property (p_wr) else $error("write without request");
  a_wdat: assert property (p_wdat) else $error("write data or lanes wrong");
  a_be: assert property (p_be) else $error("lanes set outside write");
  a_excl: assert property (p_excl) else $error("read and write together");
  a_rdat: assert property (p_rdat) else $error("read data not loaded");
endmodule

// >>> swr_events.sv
// swr_events: host event source bits with set-only and permitted-clear paths
// assumes one-cycle write strobes on pclk from the register slave
`timescale 1ns/1ps
module swr_events (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // ec side set
  input  wire logic        set_we,
  input  wire logic [15:0] set_data,
  // host side clear
  input  wire logic        clr_we,
  input  wire logic [15:0] clr_data,
  input  wire logic [15:0] clear_permit,
  // state
  output logic [15:0]      event_src,
  output logic             event_rise
);
  logic [15:0] next_event_src;
  wire  [15:0] set_bits = set_we ? (set_data & swr_pkg::EVENT_MASK) : swr_pkg::RST16;
  wire  [15:0] clr_bits = clr_we ? (clr_data & clear_permit & swr_pkg::EVENT_MASK)
                                 : swr_pkg::RST16;
  // set wins over a clear in the same cycle; zeros in set_data do nothing
  assign next_event_src = (event_src & ~clr_bits) | set_bits;
  assign event_rise     = |(set_bits & ~event_src);
  // event register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_src <= swr_pkg::RST16;
    end else begin
      event_src <= next_event_src;
    end
  end
endmodule

// >>> swr_gate.sv
// swr_gate: region-1 window ceiling check and internal address forming
// assumes requests come on pclk from the window front end, one cycle each
`timescale 1ns/1ps
module swr_gate (
  // programmed limits
  input  wire logic [15:0] read_ceiling,
  input  wire logic [15:0] write_ceiling,
  input  wire logic [31:0] base1,
  // window access
  input  wire logic [15:0] window_pointer,
  input  wire logic        rd_req,
  input  wire logic        wr_req,
  // decisions
  output logic             rd_allow,
  output logic             wr_allow,
  output logic             rd_deny,
  output logic             wr_deny,
  output logic [31:0]      mem_addr
);
  // region select and the compared pointer field
  wire        region1 = window_pointer[swr_pkg::REGION_BIT];
  wire [12:0] ptr_f   = window_pointer[swr_pkg::CEIL_HI:swr_pkg::CEIL_LO];
  wire [12:0] rd_f    = read_ceiling[swr_pkg::CEIL_HI:swr_pkg::CEIL_LO];
  wire [12:0] wr_f    = write_ceiling[swr_pkg::CEIL_HI:swr_pkg::CEIL_LO];
  wire        rd_ok   = ptr_f < rd_f;
  wire        wr_ok   = ptr_f < wr_f;
  // a denied write never reaches memory, not even a partial byte
  assign rd_allow = rd_req & region1 & rd_ok;
  assign wr_allow = wr_req & region1 & wr_ok;
  assign wr_deny  = wr_req & region1 & ~wr_ok;
  assign rd_deny  = rd_req & region1 & ~rd_ok;
  // pointer offset is byte-granular; bit 15 only selects region
  assign mem_addr = base1 + {17'h0_0000, window_pointer[14:0]};
endmodule

// >>> swr_mem_model.sv
// swr_mem_model: internal memory answering the window, counts strobes
// assumes mem_rd and mem_wr are one-cycle pulses on pclk
`timescale 1ns/1ps
module swr_mem_model (
  input wire logic        pclk, mem_rd, mem_wr,
  input wire logic [31:0] mem_addr, mem_wdata,
  input wire logic [3:0]  mem_be,
  output logic [31:0]     mem_rdata, l_addr, l_wdata,
  output logic            mem_rvalid,
  output logic [3:0]      l_be,
  output int              n_rd, n_wr
);
  initial begin
    mem_rdata = 32'h0000_0000; mem_rvalid = 0; n_rd = 0; n_wr = 0;
  end
  // data toggles when idle so a stale word is never mistaken for an answer
  always @(posedge pclk) begin
    mem_rvalid <= mem_rd;
    mem_rdata <= mem_rd ? ~mem_addr : ~mem_rdata;
    if (mem_rd || mem_wr) l_addr <= mem_addr;
    if (mem_rd) n_rd <= n_rd + 1;
    if (mem_wr) begin
      n_wr <= n_wr + 1;
      l_wdata <= mem_wdata;
      l_be <= mem_be;
    end
  end
endmodule

// >>> swr_pkg.sv
// swr_pkg: shared constants of the shared window region-1 control block
// assumes nothing; every design file refers to it by package scope
package swr_pkg;
  // register indices as printed (not multiples of four): byte address is 4x index
  localparam logic [7:0] IDX_READ_CEIL    = 8'h10;
  localparam logic [7:0] IDX_WRITE_CEIL   = 8'h12;
  localparam logic [7:0] IDX_EVENT_SET    = 8'h14;
  localparam logic [7:0] IDX_CLEAR_PERMIT = 8'h16;
  // own registers
  localparam logic [7:0] IDX_BASE1        = 8'h20;
  localparam logic [7:0] IDX_EVENT_SRC    = 8'h21;
  localparam logic [7:0] IDX_IRQ_STATUS   = 8'h22;
  localparam logic [7:0] IDX_IRQ_MASK     = 8'h23;
  localparam logic [7:0] IDX_POINTER      = 8'h24;
  // field layout
  localparam int         REGION_BIT       = 15;
  localparam int         CEIL_HI          = 14;
  localparam int         CEIL_LO          = 2;
  localparam logic [15:0] CEIL_MASK       = 16'h7ffc;
  localparam logic [15:0] EVENT_MASK      = 16'hfffe;
  localparam logic [31:0] BASE_MASK       = 32'hffff_fffc;
  localparam logic [15:0] RST16           = 16'h0000;
  localparam logic [31:0] RST32           = 32'h0000_0000;
  // interrupt status bits
  localparam int         IRQ_RD_DENY      = 0;
  localparam int         IRQ_WR_DENY      = 1;
  localparam int         IRQ_EVENT        = 2;
  localparam int         IRQ_W            = 3;
endpackage

// >>> swr_top.sv
// swr_top: shared window region-1 control with apb register slave
// assumes an apb master on pclk and a window front end giving pointer and strobes
// the slave answers every transfer in one access cycle, with no wait states
// window requests are one-cycle pulses; memory sees them one cycle later
//
// Operation
// - region-1 reads pass only below read ceiling
// - region-1 writes stored below write ceiling
// - writes at or above ceiling fully suppressed
// - ec writing one sets host event bit; here bit 0 is masked off by EVENT_MASK and never sets
// - writing zero leaves event bit unchanged
// - set field reads current event source
// - permit zero blocks host clearing that bit
// - permit one lets written one clear
// - internal address is base plus pointer bits 14:0
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module swr_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // window data port access
  input  wire logic        win_rd,
  input  wire logic        win_wr,
  input  wire logic [31:0] win_wdata,
  input  wire logic [3:0]  win_be,
  input  wire logic        host_clr_we,
  input  wire logic [15:0] host_clr_data,
  output logic [31:0]      win_rdata,
  // internal memory side
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  output logic [3:0]       mem_be,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_rvalid,
  // interrupt
  output logic             irq
);
  // control registers
  logic [15:0] read_ceiling;
  logic [15:0] write_ceiling;
  logic [15:0] clear_permit;
  logic [31:0] base1;
  logic [15:0] window_pointer;
  logic [swr_pkg::IRQ_W-1:0] irq_status;
  logic [swr_pkg::IRQ_W-1:0] irq_mask;
  logic [swr_pkg::IRQ_W-1:0] next_irq_status;

  // event block results
  logic [15:0] event_src;
  logic        event_rise;

  // gate decisions
  logic        rd_allow;
  logic        wr_allow;
  logic        rd_deny;
  logic        wr_deny;
  logic [31:0] gate_addr;

  // apb decode: one-cycle access, answer in the access phase
  wire        acc     = psel & penable;
  wire        wr_acc  = acc & pwrite;
  wire        word_ok = paddr[1:0] == 2'b00;
  wire [7:0]  idx     = paddr[9:2];
  wire        hit_rc  = word_ok && idx == swr_pkg::IDX_READ_CEIL;
  wire        hit_wc  = word_ok && idx == swr_pkg::IDX_WRITE_CEIL;
  wire        hit_es  = word_ok && idx == swr_pkg::IDX_EVENT_SET;
  wire        hit_cp  = word_ok && idx == swr_pkg::IDX_CLEAR_PERMIT;
  wire        hit_b1  = word_ok && idx == swr_pkg::IDX_BASE1;
  wire        hit_src = word_ok && idx == swr_pkg::IDX_EVENT_SRC;
  wire        hit_st  = word_ok && idx == swr_pkg::IDX_IRQ_STATUS;
  wire        hit_mk  = word_ok && idx == swr_pkg::IDX_IRQ_MASK;
  wire        hit_pt  = word_ok && idx == swr_pkg::IDX_POINTER;
  // addresses above the register page are refused; only the read word still aliases into it
  wire        in_page = ~paddr[11] & ~paddr[10];
  wire        hit_reg = hit_rc | hit_wc | hit_es | hit_cp | hit_b1 | hit_src | hit_st
                        | hit_mk | hit_pt;
  wire        hit_any = hit_reg & in_page;
  // only the low two lanes carry the 16-bit registers
  wire        lo_ok   = pstrb[0] & pstrb[1];
  wire        full_ok = &pstrb;

  // error is decided in setup so it stands with pready; reads need no lanes
  wire        lane_ok            = hit_b1 ? full_ok : lo_ok;
  wire        wr_lane_ok         = pwrite ? lane_ok : 1'b1;
  wire        next_pslverr_setup = ~(hit_any & wr_lane_ok);
  // a write lands only at the access edge, and never when it is refused
  wire        wr_take            = wr_acc & pready & ~pslverr;
  // per-register write enables
  wire        we_rc              = wr_take & hit_rc;
  wire        we_wc              = wr_take & hit_wc;
  wire        we_cp              = wr_take & hit_cp;
  wire        we_b1              = wr_take & hit_b1;
  wire        we_pt              = wr_take & hit_pt;
  wire        we_mk              = wr_take & hit_mk;
  wire        we_st              = wr_take & hit_st;

  // read words; reserved bits are forced to zero here, never stored
  wire [31:0] rw_rc  = {16'h0000, read_ceiling};
  wire [31:0] rw_wc  = {16'h0000, write_ceiling};
  wire [31:0] rw_es  = {16'h0000, event_src};
  wire [31:0] rw_cp  = {16'h0000, clear_permit};
  wire [31:0] rw_src = {16'h0000, event_src};
  wire [31:0] rw_st  = {29'h0000_0000, irq_status};
  wire [31:0] rw_mk  = {29'h0000_0000, irq_mask};
  wire [31:0] rw_pt  = {16'h0000, window_pointer};

  // read mux; an unmapped index reads zero
  wire [31:0] rd_mux =
      hit_rc  ? rw_rc :
      hit_wc  ? rw_wc :
      hit_es  ? rw_es :
      hit_cp  ? rw_cp :
      hit_b1  ? base1 :
      hit_src ? rw_src :
      hit_st  ? rw_st :
      hit_mk  ? rw_mk :
      hit_pt  ? rw_pt :
                32'h0000_0000;

  // ceiling check and address former
  swr_gate u_gate (
    .read_ceiling   (read_ceiling),
    .write_ceiling  (write_ceiling),
    .base1          (base1),
    .window_pointer (window_pointer),
    .rd_req         (win_rd),
    .wr_req         (win_wr),
    .rd_allow       (rd_allow),
    .wr_allow       (wr_allow),
    .rd_deny        (rd_deny),
    .wr_deny        (wr_deny),
    .mem_addr       (gate_addr)
  );

  // host event source bits
  swr_events u_events (
    .pclk         (pclk),
    .presetn      (presetn),
    .set_we       (wr_acc & hit_any & hit_es & lo_ok),
    .set_data     (pwdata[15:0]),
    .clr_we       (host_clr_we),
    .clr_data     (host_clr_data),
    .clear_permit (clear_permit),
    .event_src    (event_src),
    .event_rise   (event_rise)
  );

  // sticky interrupt events; set beats write-one-clear
  wire [swr_pkg::IRQ_W-1:0] irq_set = {event_rise, wr_deny, rd_deny};
  // a refused write clears nothing, so the clear rides on the write enable
  wire [swr_pkg::IRQ_W-1:0] irq_clr = we_st ? pwdata[swr_pkg::IRQ_W-1:0] : 3'b000;
  // per bit: set on its event, cleared only by a written one
  for (genvar b = 0; b < swr_pkg::IRQ_W; b++) begin : g_status
    assign next_irq_status[b] = irq_set[b] | (irq_status[b] & ~irq_clr[b]);
  end
  wire        next_irq    = |(next_irq_status & irq_mask);

  // read data is captured in setup and stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= swr_pkg::RST32;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ready is a one-cycle pulse: this slave never inserts wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & ~penable;
    end
  end

  // error is only ever raised together with ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= (psel & ~penable) ? next_pslverr_setup : 1'b0;
    end
  end

  // read ceiling: only the compared field is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_ceiling <= swr_pkg::RST16;
    end else if (we_rc) begin
      read_ceiling <= pwdata[15:0] & swr_pkg::CEIL_MASK;
    end
  end

  // write ceiling: only the compared field is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_ceiling <= swr_pkg::RST16;
    end else if (we_wc) begin
      write_ceiling <= pwdata[15:0] & swr_pkg::CEIL_MASK;
    end
  end

  // clear permission; bit 0 has no event behind it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_permit <= swr_pkg::RST16;
    end else if (we_cp) begin
      clear_permit <= pwdata[15:0] & swr_pkg::EVENT_MASK;
    end
  end

  // region base; word aligned, so a partial-lane write is refused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base1 <= swr_pkg::RST32;
    end else if (we_b1) begin
      base1 <= pwdata & swr_pkg::BASE_MASK;
    end
  end

  // window pointer; bit 15 picks the region, the rest is the offset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      window_pointer <= swr_pkg::RST16;
    end else if (we_pt) begin
      window_pointer <= pwdata[15:0];
    end
  end

  // interrupt enables, one per status bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= 3'b000;
    end else if (we_mk) begin
      irq_mask <= pwdata[swr_pkg::IRQ_W-1:0];
    end
  end

  // status flops; the per-bit next value is formed above
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 3'b000;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // interrupt line from a flop fed by the next status, so it changes at the same edge as the status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // memory strobes: denied accesses issue no strobe at all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
    end else begin
      mem_rd <= rd_allow;
      mem_wr <= wr_allow;
    end
  end

  // address holds between accesses, so an idle bus shows the last target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr <= swr_pkg::RST32;
    end else if (rd_allow | wr_allow) begin
      mem_addr <= gate_addr;
    end
  end

  // write data and lanes; lanes drop to zero outside a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_wdata <= swr_pkg::RST32;
      mem_be    <= 4'h0;
    end else begin
      mem_wdata <= wr_allow ? win_wdata : mem_wdata;
      mem_be    <= wr_allow ? win_be : 4'h0;
    end
  end

  // data port load only from a permitted read return; a refused read
  // raises no strobe, so no return comes and the port keeps its old word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_rdata <= swr_pkg::RST32;
    end else if (mem_rvalid) begin
      win_rdata <= mem_rdata;
    end
  end
endmodule

// >>> tb_swr_top.sv
// tb_swr_top: register, window and event tests of swr_top
// assumes swr_top, swr_mem_model and swr_assertions compiled before
`timescale 1ns/1ps
module tb_swr_top;
  logic pclk, presetn, psel, penable, pwrite, win_rd, win_wr, host_clr_we;
  logic pready, pslverr, mem_rd, mem_wr, mem_rvalid, irq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, win_wdata, win_rdata, mem_addr, mem_wdata, mem_rdata, rd;
  logic [31:0] l_addr, l_wdata;
  logic [15:0] host_clr_data;
  logic [3:0]  win_be, mem_be, l_be, pstrb;
  int miscompares, n_checks, n_rd, n_wr;
  swr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .win_rd(win_rd), .win_wr(win_wr),
    .win_wdata(win_wdata), .win_be(win_be), .host_clr_we(host_clr_we),
    .host_clr_data(host_clr_data), .win_rdata(win_rdata), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
    .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .irq(irq));
  swr_mem_model mem (.pclk(pclk), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_rdata(mem_rdata), .l_addr(l_addr),
    .l_wdata(l_wdata), .mem_rvalid(mem_rvalid), .l_be(l_be), .n_rd(n_rd), .n_wr(n_wr));
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  task chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // the request stands until the rising edge at which pready is sampled high;
  // a slave that never answers is ended by the watchdog
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1;
    penable <= 0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 0;
    penable <= 0;
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(0, a, 32'h0000_0000);
    chk(nm, rd, e);
  endtask
  task win(input logic w, input logic [15:0] p);
    apb(1, 12'h090, {16'h0000, p});
    @(posedge pclk) begin win_rd <= !w; win_wr <= w; end
    @(posedge pclk) begin win_rd <= 0; win_wr <= 0; end
    repeat (4) @(posedge pclk);
  endtask
  task clr(input logic [15:0] d);
    @(posedge pclk) begin host_clr_we <= 1; host_clr_data <= d; end
    @(posedge pclk) host_clr_we <= 0;
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 4'hf;
    win_rd = 0; win_wr = 0; win_wdata = 0; win_be = 0; host_clr_we = 0; host_clr_data = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 4; i++) rc(12'h040 + 12'(i * 8), 32'h0000_0000, "reset");
    apb(0, 12'h0c0, 32'h0000_0000); chk("unmapped", {31'h0, er}, 32'h1);
    apb(1, 12'h040, 32'hffff_ffff); rc(12'h040, 32'h0000_7ffc, "ceil_bits");
    apb(1, 12'h040, 32'h0000_0010);
    apb(1, 12'h048, 32'h0000_0010);
    pstrb <= 4'h1;
    apb(1, 12'h048, 32'h0000_0040);
    pstrb <= 4'hf;
    chk("strb_err", {31'h0, er}, 32'h1);
    rc(12'h048, 32'h0000_0010, "strb_nowr");
    apb(1, 12'h080, 32'h1000_0000);
    win_wdata <= 32'hcafe_f00d;
    win_be <= 4'h6;
    win(0, 16'h800c); chk("rd_n", n_rd, 1);
    chk("rd_addr", l_addr, 32'h1000_000c);
    chk("rd_data", win_rdata, ~32'h1000_000c);
    win(0, 16'h8010); chk("rd_deny", n_rd, 1);
    win(1, 16'h8008); chk("wr_n", n_wr, 1);
    chk("wr_addr", l_addr, 32'h1000_0008);
    chk("wr_data", l_wdata, 32'hcafe_f00d);
    chk("wr_be", {28'h0, l_be}, 32'h6);
    win(1, 16'h8010); chk("wr_deny", n_wr, 1);
    win(1, 16'h0008); chk("region0", n_wr, 1);
    rc(12'h088, 32'h0000_0003, "irq_status");
    chk("irq_masked", {31'h0, irq}, 32'h0);
    apb(1, 12'h08c, 32'h0000_0007); repeat (2) @(negedge pclk);
    chk("irq_up", {31'h0, irq}, 32'h1);
    apb(1, 12'h088, 32'h0000_0007); apb(1, 12'h08c, 32'h0000_0000);
    rc(12'h088, 32'h0000_0000, "irq_cleared"); chk("irq_down", {31'h0, irq}, 32'h0);
    apb(1, 12'h050, 32'h0000_00a5); rc(12'h050, 32'h0000_00a4, "set");
    apb(1, 12'h050, 32'h0000_0000); rc(12'h050, 32'h0000_00a4, "set_zero");
    rc(12'h084, 32'h0000_00a4, "src_view");
    clr(16'h00a4); rc(12'h084, 32'h0000_00a4, "no_clear");
    apb(1, 12'h058, 32'h0000_0005); rc(12'h058, 32'h0000_0004, "permit");
    clr(16'h00a4); rc(12'h084, 32'h0000_00a0, "clear");
    give_verdict;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    give_verdict;
  end
endmodule
bind swr_top swr_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .win_rd(win_rd), .win_wr(win_wr), .mem_rd(mem_rd),
  .mem_wr(mem_wr), .mem_rvalid(mem_rvalid), .win_be(win_be), .mem_be(mem_be),
  .win_wdata(win_wdata), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
  .win_rdata(win_rdata));
